// file: bcr_pkg.sv
// Package: register map, field layout, timing constants and carrier types
package bcr_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_CONTROLLER_CONTROL = 5'h00;
  localparam logic [4:0] IDX_OPERATIONAL_CONDITION = 5'h01;
  localparam logic [4:0] IDX_CURRENT_BUS_COMMAND = 5'h02;
  localparam logic [4:0] IDX_INTERRUPT_ENABLE_MASK = 5'h03;
  localparam logic [4:0] IDX_INTERRUPT_PENDING_FLAGS = 5'h04;
  localparam logic [4:0] IDX_INTERRUPT_LOG_POINTER = 5'h05;
  localparam logic [4:0] IDX_SELF_TEST_RESULT = 5'h06;
  localparam logic [4:0] IDX_FRAME_TIMER_VALUE = 5'h07;
  localparam logic [4:0] IDX_COMMAND_BLOCK_POINTER = 5'h08;
  localparam logic [4:0] IDX_BLOCK_INIT_COUNT = 5'h0A;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 6;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_RUN = 15;
  localparam int CTL_SELF_TEST = 14;
  localparam int CTL_SOFT_RESET = 13;
  localparam int CTL_EXT_TIMER = 10;
  localparam int CTL_AUTO_STATUS = 9;
  localparam int CTL_BUFFER = 6;
  localparam int CTL_BROADCAST = 4;
  localparam int CTL_RETRY_ALT = 2;
  localparam int CTL_INT_LOG = 1;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hE656;

  // ---------------------------------------------------------------
  // Operational condition fields
  // ---------------------------------------------------------------
  localparam int OPS_MODE_MSB = 9;
  localparam int OPS_MODE_LSB = 8;
  localparam int OPS_PROTOCOL = 7;
  localparam int OPS_LOCK = 6;
  localparam int OPS_AUTO_INIT = 5;
  localparam int OPS_EXECUTING = 3;
  localparam int OPS_READY = 1;
  localparam int OPS_ACTIVE = 0;

  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [1:0] MODE_BUS_CONTROLLER = 2'h0;
  localparam logic [1:0] MODE_REMOTE_TERMINAL = 2'h1;
  localparam logic [1:0] MODE_MONITOR = 2'h2;
  localparam logic [1:0] MODE_MONITOR_TERMINAL = 2'h3;
  localparam logic [4:0] BROADCAST_ADDRESS = 5'h1F;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int SOFT_RESET_NS = 5000;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int A_RESPONSE_US = 9;
  localparam int A_RESPONSE_CYCLES = A_RESPONSE_US * (CLK_HZ / 1000000);
  localparam int B_RESPONSE_US = 14;
  localparam int B_RESPONSE_CYCLES = B_RESPONSE_US * (CLK_HZ / 1000000);
  localparam int FRAME_TICK_DIV = 25;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    BCR_IDLE = 5'b00001,
    BCR_TEST = 5'b00010,
    BCR_RUN = 5'b00100,
    BCR_HALTING = 5'b01000,
    BCR_SRESET = 5'b10000
  } bcr_fsm_t;

  typedef struct packed {
    logic ext_timer_clock_en;
    logic buffer_mode_en;
    logic broadcast_en;
    logic retry_bus_alternate_en;
    logic interrupting_logging_spare;
    logic interrupt_logging_en;
    logic [1:0] operating_mode_select;
    logic protocol_variant_select;
    logic auto_status_word_switch;
    logic a_variant_timing;
    logic auto_transmit_status;
    logic bus_controller_mode;
    logic remote_terminal_mode;
    logic monitor_mode;
    logic [15:0] response_limit_cycles;
  } bcr_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] idx;
    logic [15:0] wdata;
  } bcr_reg_access_t;

endpackage : bcr_pkg

// file: bcr_ahb_front.sv
// AHB-Lite slave front end: one wait state, registered read data
`timescale 1ns/1ps
module bcr_ahb_front
(
  input wire logic ref_clk,
  input wire logic soft_reset_request,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [15:0] rdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output bcr_pkg::bcr_reg_access_t acc
);

  typedef struct packed {
    logic busy;
    logic write;
    logic mapped;
    logic [4:0] idx;
    logic readyout;
    logic [31:0] rd;
  } bcr_front_t;

  bcr_front_t st;
  bcr_front_t next_st;
  logic take;

  // Only whole-word transfers are decoded; other sizes behave as unmapped
  assign take = hsel & htrans[1] & hready;

  always_comb
  begin
    next_st = st;
    acc.wr = st.busy & st.write & st.mapped;
    acc.rd = st.busy & ~st.write & st.mapped;
    acc.idx = st.idx;
    acc.wdata = hwdata[15:0];
    if (st.busy)
    begin
      next_st.busy = 1'b0;
      next_st.readyout = 1'b1;
      next_st.rd = (st.mapped & ~st.write) ? {16'h0000, rdata} : 32'h0000_0000;
    end
    else if (take)
    begin
      next_st.busy = 1'b1;
      next_st.readyout = 1'b0;
      next_st.write = hwrite;
      next_st.mapped = (hsize == 3'h2) && (haddr[31:bcr_pkg::ADDR_IDX_MSB + 1] == '0)
        && (haddr[1:0] == 2'h0);
      next_st.idx = haddr[bcr_pkg::ADDR_IDX_MSB:bcr_pkg::ADDR_IDX_LSB];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (soft_reset_request)
      st <= '{busy: 1'b0, write: 1'b0, mapped: 1'b0, idx: 5'h00, readyout: 1'b1,
              rd: 32'h0000_0000};
    else
      st <= next_st;
  end

  assign hreadyout = st.readyout;
  assign hresp = 1'b0;
  assign hrdata = st.rd;

endmodule : bcr_ahb_front

// file: bcr_frame_tick.sv
// Minor frame counter tick: internal divider or external timer clock edges
`timescale 1ns/1ps
module bcr_frame_tick
#(
  parameter int DIV = bcr_pkg::FRAME_TICK_DIV
)
(
  input wire logic ref_clk,
  input wire logic soft_reset_request,
  input wire logic ext_timer_clock_en,
  input wire logic ext_timer_clock,
  output logic tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic ext_prev;
    logic [CW-1:0] count;
    logic tick;
  } bcr_tick_t;

  bcr_tick_t st;
  bcr_tick_t next_st;

  initial
  begin
    if (DIV < 2)
      $error("bcr_frame_tick: DIV must be at least 2");
  end

  always_comb
  begin
    next_st = st;
    next_st.ext_prev = ext_timer_clock;
    next_st.tick = 1'b0;
    if (ext_timer_clock_en)
    begin
      // External clock is taken as synchronous; a rising edge is one tick
      next_st.count = '0;
      next_st.tick = ext_timer_clock & ~st.ext_prev;
    end
    else if (st.count == CW'(DIV - 1))
    begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end
    else
      next_st.count = st.count + CW'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (soft_reset_request)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule : bcr_frame_tick

// file: bcr_regs.sv
// Control and operational status registers of the bus controller
`timescale 1ns/1ps
module bcr_regs
#(
  parameter int SOFT_RESET_LEN = bcr_pkg::SOFT_RESET_CYCLES,
  parameter int A_LIMIT = bcr_pkg::A_RESPONSE_CYCLES,
  parameter int B_LIMIT = bcr_pkg::B_RESPONSE_CYCLES,
  parameter int TICK_DIV = bcr_pkg::FRAME_TICK_DIV
)
(
  input wire logic ref_clk,
  input wire logic soft_reset_request,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device pins
  input wire logic lock_n,
  input wire logic auto_init_enable_pin_n,
  input wire logic [1:0] pin_operating_mode_select,
  input wire logic pin_protocol_variant_select,
  input wire logic ext_timer_clock,
  input wire logic [4:0] terminal_address,
  output logic device_ready_out_n,
  output logic terminal_active_out_n,
  // Command engine side
  input wire logic opcode_done,
  input wire logic processing_done,
  input wire logic end_of_list_block,
  input wire logic [15:0] next_block_pointer,
  input wire logic self_test_done,
  input wire logic [15:0] self_test_word,
  input wire logic [15:0] current_command_word,
  input wire logic [15:0] pending_flags,
  input wire logic [15:0] frame_timer_count,
  output bcr_pkg::bcr_cfg_t cfg,
  output logic executing_flag,
  output logic self_test_active,
  output logic internal_reset,
  output logic address_is_broadcast,
  output logic frame_count_tick,
  output logic [15:0] interrupt_enable_mask,
  output logic [15:0] interrupt_log_pointer,
  output logic [15:0] command_block_pointer,
  output logic [15:0] block_init_count
);

  localparam int SRW = $clog2(SOFT_RESET_LEN + 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    bcr_pkg::bcr_fsm_t fsm;
    logic [15:0] controller_control;
    logic [2:0] op_written;
    logic op_valid;
    logic [15:0] interrupt_enable_mask;
    logic [15:0] interrupt_log_pointer;
    logic [15:0] self_test_result;
    logic [15:0] command_block_pointer;
    logic [15:0] block_init_count;
    logic [SRW-1:0] sr_count;
    logic lock_caught;
    logic lock_latched;
    logic ready;
    logic active;
    logic ready_n, active_n;
    logic broadcast31;
    bcr_pkg::bcr_cfg_t cfg;
  } bcr_regs_t;

  bcr_regs_t st;
  bcr_regs_t next_st;
  bcr_pkg::bcr_reg_access_t acc;
  logic [15:0] rdata;
  logic [15:0] opcond;
  logic pins_rule;
  logic [1:0] mode_eff;
  logic proto_eff;
  logic [15:0] ctl;

  initial
  begin
    if (SOFT_RESET_LEN < 1 || A_LIMIT < 1 || B_LIMIT < 1 || A_LIMIT > 65535 || B_LIMIT > 65535)
      $error("bcr_regs: timing parameters out of range");
  end

  // ---------------------------------------------------------------
  // Bus front end and frame tick
  // ---------------------------------------------------------------
  bcr_ahb_front u_front
  (
    .ref_clk(ref_clk),
    .soft_reset_request(soft_reset_request),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .rdata(rdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .acc(acc)
  );

  bcr_frame_tick #(.DIV(TICK_DIV)) u_tick
  (
    .ref_clk(ref_clk),
    .soft_reset_request(soft_reset_request),
    .ext_timer_clock_en(st.cfg.ext_timer_clock_en),
    .ext_timer_clock(ext_timer_clock),
    .tick(frame_count_tick)
  );

  // ---------------------------------------------------------------
  // Operational status view
  // ---------------------------------------------------------------
  // Until software writes the register, and always while locked, the pins rule
  assign pins_rule = ~lock_n | ~st.op_valid;
  assign mode_eff = pins_rule ? pin_operating_mode_select : st.op_written[2:1];
  assign proto_eff = pins_rule ? pin_protocol_variant_select : st.op_written[0];

  always_comb
  begin
    opcond = bcr_pkg::REG_RESET;
    opcond[bcr_pkg::OPS_MODE_MSB:bcr_pkg::OPS_MODE_LSB] = mode_eff;
    opcond[bcr_pkg::OPS_PROTOCOL] = proto_eff;
    opcond[bcr_pkg::OPS_LOCK] = st.lock_latched;
    opcond[bcr_pkg::OPS_AUTO_INIT] = ~auto_init_enable_pin_n;
    opcond[bcr_pkg::OPS_EXECUTING] = st.active;
    opcond[bcr_pkg::OPS_READY] = st.ready;
    opcond[bcr_pkg::OPS_ACTIVE] = st.active;
  end

  // ---------------------------------------------------------------
  // Read mux; unmapped indices read zero
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (acc.idx)
      bcr_pkg::IDX_CONTROLLER_CONTROL: rdata = st.controller_control;
      bcr_pkg::IDX_OPERATIONAL_CONDITION: rdata = opcond;
      bcr_pkg::IDX_CURRENT_BUS_COMMAND: rdata = current_command_word;
      bcr_pkg::IDX_INTERRUPT_ENABLE_MASK: rdata = st.interrupt_enable_mask;
      bcr_pkg::IDX_INTERRUPT_PENDING_FLAGS: rdata = pending_flags;
      bcr_pkg::IDX_INTERRUPT_LOG_POINTER: rdata = st.interrupt_log_pointer;
      bcr_pkg::IDX_SELF_TEST_RESULT: rdata = st.self_test_result;
      bcr_pkg::IDX_FRAME_TIMER_VALUE: rdata = frame_timer_count;
      bcr_pkg::IDX_COMMAND_BLOCK_POINTER: rdata = st.command_block_pointer;
      bcr_pkg::IDX_BLOCK_INIT_COUNT: rdata = st.block_init_count;
      default: rdata = bcr_pkg::REG_RESET;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    ctl = acc.wdata & bcr_pkg::CTL_WRITE_MASK;

    // Lock level is caught on the first edge after reset release
    if (!st.lock_caught)
    begin
      next_st.lock_caught = 1'b1;
      next_st.lock_latched = ~lock_n;
    end
    next_st.ready = st.lock_caught & (st.fsm != bcr_pkg::BCR_SRESET);

    // Plain register writes; the host keeps configuration still while running
    if (acc.wr)
    begin
      unique case (acc.idx)
        bcr_pkg::IDX_CONTROLLER_CONTROL:
        begin
          next_st.controller_control = ctl;
        end
        bcr_pkg::IDX_OPERATIONAL_CONDITION:
        begin
          if (lock_n)
          begin
            next_st.op_written = {acc.wdata[bcr_pkg::OPS_MODE_MSB:bcr_pkg::OPS_MODE_LSB],
                                  acc.wdata[bcr_pkg::OPS_PROTOCOL]};
            next_st.op_valid = 1'b1;
          end
        end
        bcr_pkg::IDX_INTERRUPT_ENABLE_MASK: next_st.interrupt_enable_mask = acc.wdata;
        bcr_pkg::IDX_INTERRUPT_LOG_POINTER: next_st.interrupt_log_pointer = acc.wdata;
        bcr_pkg::IDX_SELF_TEST_RESULT: next_st.self_test_result = acc.wdata;
        bcr_pkg::IDX_COMMAND_BLOCK_POINTER: next_st.command_block_pointer = acc.wdata;
        bcr_pkg::IDX_BLOCK_INIT_COUNT: next_st.block_init_count = acc.wdata;
        default:
        begin
        end
      endcase
    end

    unique case (st.fsm)
      bcr_pkg::BCR_IDLE:
      begin
        if (acc.wr && acc.idx == bcr_pkg::IDX_CONTROLLER_CONTROL)
        begin
          if (ctl[bcr_pkg::CTL_SELF_TEST])
          begin
            next_st.fsm = bcr_pkg::BCR_TEST;
            next_st.controller_control[bcr_pkg::CTL_RUN] = 1'b0;
          end
          else if (ctl[bcr_pkg::CTL_RUN])
          begin
            next_st.fsm = bcr_pkg::BCR_RUN;
          end
        end
      end
      bcr_pkg::BCR_TEST:
      begin
        if (self_test_done)
        begin
          next_st.fsm = bcr_pkg::BCR_IDLE;
          next_st.self_test_result = self_test_word;
          next_st.controller_control[bcr_pkg::CTL_SELF_TEST] = 1'b0;
        end
      end
      bcr_pkg::BCR_RUN:
      begin
        if (processing_done)
        begin
          next_st.fsm = bcr_pkg::BCR_IDLE;
          next_st.controller_control[bcr_pkg::CTL_RUN] = 1'b0;
        end
        else if (acc.wr && acc.idx == bcr_pkg::IDX_CONTROLLER_CONTROL
                 && !ctl[bcr_pkg::CTL_RUN])
        begin
          next_st.fsm = bcr_pkg::BCR_HALTING;
        end
      end
      bcr_pkg::BCR_HALTING:
      begin
        if (opcode_done || processing_done)
        begin
          next_st.fsm = bcr_pkg::BCR_IDLE;
          if (!end_of_list_block)
            next_st.command_block_pointer = next_block_pointer;
        end
      end
      bcr_pkg::BCR_SRESET:
      begin
        if (st.sr_count == SRW'(1))
          next_st.fsm = bcr_pkg::BCR_IDLE;
        next_st.sr_count = st.sr_count - SRW'(1);
      end
    endcase

    // Soft reset clears the registers a master reset would, except the lock catch; the frame tick divider and bus front end are not reset
    if ((st.fsm == bcr_pkg::BCR_SRESET) || (acc.wr && st.ready
        && acc.idx == bcr_pkg::IDX_CONTROLLER_CONTROL && ctl[bcr_pkg::CTL_SOFT_RESET]))
    begin
      next_st.controller_control = bcr_pkg::REG_RESET;
      next_st.op_written = '0;
      next_st.op_valid = 1'b0;
      next_st.interrupt_enable_mask = bcr_pkg::REG_RESET;
      next_st.interrupt_log_pointer = bcr_pkg::REG_RESET;
      next_st.self_test_result = bcr_pkg::REG_RESET;
      next_st.command_block_pointer = bcr_pkg::REG_RESET;
      next_st.block_init_count = bcr_pkg::REG_RESET;
      next_st.ready = 1'b0;
      if (st.fsm != bcr_pkg::BCR_SRESET)
      begin
        next_st.fsm = bcr_pkg::BCR_SRESET;
        next_st.sr_count = SRW'(SOFT_RESET_LEN);
      end
    end

    // Executing and active span run and halting until completion
    next_st.active = (next_st.fsm == bcr_pkg::BCR_RUN)
                     || (next_st.fsm == bcr_pkg::BCR_HALTING);
    next_st.active_n = ~next_st.active;
    next_st.ready_n = ~next_st.ready;

    // Configuration decode, registered for the engine
    next_st.cfg.ext_timer_clock_en = st.controller_control[bcr_pkg::CTL_EXT_TIMER];
    next_st.cfg.buffer_mode_en = st.controller_control[bcr_pkg::CTL_BUFFER];
    next_st.cfg.broadcast_en = st.controller_control[bcr_pkg::CTL_BROADCAST];
    next_st.cfg.retry_bus_alternate_en = st.controller_control[bcr_pkg::CTL_RETRY_ALT];
    next_st.cfg.interrupting_logging_spare = 1'b0;
    next_st.cfg.interrupt_logging_en = st.controller_control[bcr_pkg::CTL_INT_LOG];
    next_st.cfg.operating_mode_select = mode_eff;
    next_st.cfg.protocol_variant_select = proto_eff;
    next_st.cfg.auto_status_word_switch = st.controller_control[bcr_pkg::CTL_AUTO_STATUS];
    next_st.cfg.a_variant_timing = proto_eff;
    next_st.cfg.auto_transmit_status = proto_eff
      & st.controller_control[bcr_pkg::CTL_AUTO_STATUS];
    next_st.cfg.response_limit_cycles = proto_eff ? 16'(A_LIMIT) : 16'(B_LIMIT);
    next_st.cfg.bus_controller_mode = (mode_eff == bcr_pkg::MODE_BUS_CONTROLLER);
    next_st.cfg.remote_terminal_mode = (mode_eff == bcr_pkg::MODE_REMOTE_TERMINAL)
      || (mode_eff == bcr_pkg::MODE_MONITOR_TERMINAL);
    next_st.cfg.monitor_mode = (mode_eff == bcr_pkg::MODE_MONITOR)
      || (mode_eff == bcr_pkg::MODE_MONITOR_TERMINAL);
    // With broadcast off, address 31 is just another terminal
    next_st.broadcast31 = st.controller_control[bcr_pkg::CTL_BROADCAST]
      && (terminal_address == bcr_pkg::BROADCAST_ADDRESS);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (soft_reset_request)
    begin
      st <= '{fsm: bcr_pkg::BCR_IDLE, ready_n: 1'b1, active_n: 1'b1, default: '0};
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg = st.cfg;
  assign executing_flag = st.active;
  assign self_test_active = (st.fsm == bcr_pkg::BCR_TEST);
  assign internal_reset = (st.fsm == bcr_pkg::BCR_SRESET);
  assign address_is_broadcast = st.broadcast31;
  assign device_ready_out_n = st.ready_n;
  assign terminal_active_out_n = st.active_n;
  assign interrupt_enable_mask = st.interrupt_enable_mask;
  assign interrupt_log_pointer = st.interrupt_log_pointer;
  assign command_block_pointer = st.command_block_pointer;
  assign block_init_count = st.block_init_count;

endmodule : bcr_regs

// file: bcr_regs_end.sv
// Spare file: holds no logic of the register bank

// file: bcr_eng_model.sv
// Command engine model: done pulses for run, halt and self-test
`timescale 1ns/1ps
module bcr_eng_model
(
  input wire logic ref_clk,
  input wire logic executing_flag,
  input wire logic self_test_active,
  input wire logic end_of_list_block,
  output logic opcode_done,
  output logic processing_done,
  output logic self_test_done
);
  // Slow opcodes, so the host can look at status while a run is on
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge ref_clk)
  begin
    cnt <= (executing_flag || self_test_active) ? cnt + 4'h1 : 4'h0;
  end
  assign opcode_done = executing_flag && cnt == 4'hF;
  assign processing_done = opcode_done && end_of_list_block;
  assign self_test_done = self_test_active && cnt == 4'h5;
endmodule : bcr_eng_model

// file: bcr_regs_chk.sv
// Checker: bus timing and engine handshake properties of the register bank
`timescale 1ns/1ps
module bcr_regs_chk
#(
  parameter int SOFT_RESET_LEN = 4
)
(
  input wire logic ref_clk,
  input wire logic soft_reset_request,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic executing_flag,
  input wire logic terminal_active_out_n,
  input wire logic device_ready_out_n,
  input wire logic opcode_done,
  input wire logic processing_done,
  input wire logic [4:0] terminal_address,
  input wire logic address_is_broadcast,
  input wire logic frame_count_tick,
  input wire bcr_pkg::bcr_cfg_t cfg,
  input wire logic internal_reset,
  input wire logic self_test_active,
  input wire logic self_test_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (soft_reset_request);
  a_wait_one: assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("transfer not one wait state");
  a_okay_resp: assert property (!hresp) else $error("error response");
  a_active_pin: assert property (terminal_active_out_n == !executing_flag)
    else $error("active pin differs from executing");
  a_exec_holds: assert property (executing_flag && !processing_done && !opcode_done
    && !$past(processing_done) && !$past(opcode_done) && !internal_reset |=> executing_flag)
    else $error("run dropped without completion");
  a_bcast_addr: assert property (address_is_broadcast |-> $past(terminal_address) == 5'h1F)
    else $error("broadcast flag on other address");
  a_tick_gap: assert property (frame_count_tick && !cfg.ext_timer_clock_en |=>
    !frame_count_tick [*8]) else $error("frame ticks too close");
  a_sreset_len: assert property ($rose(internal_reset) |->
    (internal_reset && device_ready_out_n) [*4] ##1 !internal_reset)
    else $error("soft reset length wrong");
  a_test_exit: assert property (self_test_active && self_test_done |=> !self_test_active)
    else $error("self-test did not end");
  cover property ($rose(executing_flag));
  cover property ($rose(internal_reset));
  cover property (self_test_active && self_test_done);
endmodule : bcr_regs_chk
bind bcr_regs bcr_regs_chk #(.SOFT_RESET_LEN(SOFT_RESET_LEN)) u_chk (.*);

// file: bus_ctrl_config_status_regs_tb.sv
// Testbench: register bank driven over AHB-Lite
`timescale 1ns/1ps
module bus_ctrl_config_status_regs_tb;
  logic ref_clk, soft_reset_request, hsel, hwrite, lock_n, auto_init_enable_pin_n, ext_timer_clock;
  logic pin_protocol_variant_select, end_of_list_block, hreadyout, hresp, executing_flag;
  logic device_ready_out_n, terminal_active_out_n, self_test_active, internal_reset;
  logic address_is_broadcast, frame_count_tick, opcode_done, processing_done, self_test_done;
  logic [1:0] htrans, pin_operating_mode_select;
  logic [2:0] hsize;
  logic [4:0] terminal_address;
  logic [15:0] next_block_pointer, interrupt_enable_mask, interrupt_log_pointer;
  logic [15:0] command_block_pointer, block_init_count;
  logic [31:0] haddr, hwdata, hrdata, q;
  bcr_pkg::bcr_cfg_t cfg;
  int err_total = 0, checks_done = 0, ticks = 0;
  logic [4:0] zl [9] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h1F};
  logic [2:0] mt [4] = '{3'h4, 3'h2, 3'h1, 3'h3};
  bcr_regs #(.SOFT_RESET_LEN(4)) u_dut (.hready(hreadyout), .self_test_word(16'h00A5),
    .current_command_word(16'h0C3C), .pending_flags(16'h0000),
    .frame_timer_count(16'h0000), .*);
  bcr_eng_model u_eng (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (frame_count_tick) ticks++;
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, s, e);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] i, input logic [15:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {25'h0, i, 2'h0};
    do @(posedge ref_clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge ref_clk); while (!hreadyout);
    q = hrdata;
  endtask : bus
  task rd(input logic [4:0] i, input logic [15:0] e);
    bus(1'b0, i, 16'h0);
    chk(q, {16'h0, e});
  endtask : rd
  task results;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  initial
  begin
    #200000;
    err_total++;
    results;
  end
  initial
  begin
    {soft_reset_request, hsel, htrans, hwrite, hsize, haddr, hwdata} = {1'b1, 4'h0, 3'h2, 64'h0};
    {lock_n, auto_init_enable_pin_n, pin_operating_mode_select} = 4'hA;
    {pin_protocol_variant_select, ext_timer_clock, terminal_address} = 7'h5F;
    {end_of_list_block, next_block_pointer} = 17'h0;
    repeat (2) @(posedge ref_clk);
    soft_reset_request <= 1'b0;
    bus(1'b1, 5'h09, 16'hFFFF);
    bus(1'b1, 5'h02, 16'hFFFF);
    foreach (zl[k]) rd(zl[k], 16'h0000);
    rd(5'h02, 16'h0C3C);
    rd(5'h01, 16'h02A2);
    bus(1'b1, 5'h00, 16'h0FFF);
    rd(5'h00, 16'h0656);
    @(negedge ref_clk);
    ticks = 0;
    repeat (6)
    begin
      repeat (6) @(posedge ref_clk);
      ext_timer_clock <= ~ext_timer_clock;
    end
    repeat (6) @(negedge ref_clk);
    chk(ticks, 3);
    chk({cfg.buffer_mode_en, cfg.retry_bus_alternate_en, cfg.interrupt_logging_en}, 3'h7);
    chk(address_is_broadcast, 1'b1);
    bus(1'b1, 5'h00, 16'h0000);
    repeat (3) @(negedge ref_clk);
    chk({cfg.buffer_mode_en, address_is_broadcast}, 2'h0);
    $display("control register test done");
    bus(1'b1, 5'h01, 16'h0100);
    rd(5'h01, 16'h0122);
    lock_n <= 1'b0;
    bus(1'b1, 5'h01, 16'h0300);
    rd(5'h01, 16'h02A2);
    lock_n <= 1'b1;
    rd(5'h01, 16'h0122);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 5'h01, {6'h0, i[1:0], i[0], 7'h0});
      bus(1'b1, 5'h00, {6'h0, i[1], 9'h0});
      repeat (3) @(negedge ref_clk);
      chk({cfg.bus_controller_mode, cfg.remote_terminal_mode, cfg.monitor_mode}, mt[i]);
      chk({cfg.a_variant_timing, cfg.auto_transmit_status}, {i[0], i[0] & i[1]});
      chk(cfg.response_limit_cycles, i[0] ? 16'h00E1 : 16'h015E);
    end
    $display("status and mode test done");
    for (int e = 0; e < 2; e++)
    begin
      @(posedge ref_clk);
      end_of_list_block <= e[0];
      next_block_pointer <= e[0] ? 16'h0DEF : 16'h0ABC;
      bus(1'b1, 5'h00, 16'h8000);
      repeat (2) @(negedge ref_clk);
      chk(executing_flag, 1'b1);
      rd(5'h01, 16'h03AB);
      if (e == 0) bus(1'b1, 5'h00, 16'h0000);
      for (int k = 0; k < 40 && executing_flag; k++) @(posedge ref_clk);
      rd(5'h08, 16'h0ABC);
      chk(command_block_pointer, 16'h0ABC);
      rd(5'h00, 16'h0000);
    end
    bus(1'b1, 5'h00, 16'hC000);
    @(negedge ref_clk);
    chk({self_test_active, executing_flag}, 2'h2);
    for (int k = 0; k < 40 && self_test_active; k++) @(posedge ref_clk);
    rd(5'h06, 16'h00A5);
    rd(5'h00, 16'h0000);
    $display("run and self-test done");
    bus(1'b1, 5'h03, 16'h1234);
    chk(interrupt_enable_mask, 16'h1234);
    bus(1'b1, 5'h05, 16'h0FE0);
    bus(1'b1, 5'h0A, 16'h0033);
    chk({interrupt_log_pointer, block_init_count}, 32'h0FE0_0033);
    bus(1'b1, 5'h00, 16'h2000);
    @(negedge ref_clk);
    chk({internal_reset, device_ready_out_n}, 2'h3);
    repeat (10) @(posedge ref_clk);
    rd(5'h03, 16'h0000);
    rd(5'h00, 16'h0000);
    chk({interrupt_log_pointer, block_init_count}, 32'h0000_0000);
    chk(command_block_pointer, 16'h0000);
    $display("soft reset test done");
    results;
  end
endmodule : bus_ctrl_config_status_regs_tb
